// ---- single_wire_slot_pullup_ctrl.sv ----
// Waveform engine of a single-wire bus master: reset cycles, write and
// read slots, reply sampling, fast-rise and strong pullup control.
// Assumes an open-drain line outside, a threshold comparator for the
// pullup-on level, and a host that sequences commands over plain ports.
`timescale 1ns/1ps
module single_wire_slot_pullup_ctrl
  import single_wire_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Command request and answer
  input wire logic cmdValid,
  input wire slot_kind_t cmdKind,
  input wire logic cmdLast,
  output logic cmdReady,
  output logic doneValid,
  output logic readBit,
  // Control settings
  input wire logic overdrive,
  input wire logic fastRisePullupEnable,
  input wire logic strongPullupArm,
  input wire logic strongPullupDisable,
  input wire logic masterReset,
  // Timing configuration writes
  input wire logic cfgWrite,
  input wire logic cfgOverdrive,
  input wire timing_par_t cfgSelect,
  input wire logic [TIME_W-1:0] cfgValue,
  // Status
  output logic strongPullupArmed,
  output logic strongPullupOn,
  // Line pins
  input wire logic lineIn,
  input wire logic pullupOnThreshold,
  output logic lineOut,
  output logic lineOe,
  output logic weakPullupOn,
  output logic fastRisePullup
);

  slot_timer_if tmr ();
  slot_timer u_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tmr(tmr)
  );

  slot_state_t state_reg;
  slot_kind_t kind_reg;
  logic last_reg;
  logic speed_reg;
  logic [1:0] lineSync_reg;
  logic [1:0] aboveSync_reg;
  logic armed_reg;
  logic fastRise_reg;
  logic spuArm_reg;
  logic spu_reg;
  logic done_reg;
  logic bit_reg;
  logic lineNow;
  logic aboveNow;
  logic startSlot;
  logic lowEnd;
  logic slotEnd;
  logic riseEnd;
  logic sampleNow;
  logic [TIME_W-1:0] w1l_reg [2];
  logic [TIME_W-1:0] w0l_reg [2];
  logic [TIME_W-1:0] rec_reg [2];
  logic [TIME_W-1:0] msr_reg [2];
  logic [TIME_W-1:0] slot_reg [2];
  logic [TIME_W-1:0] rstl_reg [2];
  logic [TIME_W-1:0] lowTime;
  logic [TIME_W-1:0] riseTime;
  logic [TIME_W-1:0] endTime;

  // Two flip-flop synchronisers on the line and comparator pins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineSync_reg <= 2'h3;
      aboveSync_reg <= 2'h3;
    end else begin
      lineSync_reg <= {lineSync_reg[0], lineIn};
      aboveSync_reg <= {aboveSync_reg[0], pullupOnThreshold};
    end
  end
  assign lineNow = lineSync_reg[1];
  assign aboveNow = aboveSync_reg[1];

  // Timing sets in cycles, one per speed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      w1l_reg <= '{STD_W1L_CYC, OD_W1L_CYC};
      w0l_reg <= '{STD_W0L_CYC, OD_W0L_CYC};
      rec_reg <= '{STD_REC_CYC, OD_REC_CYC};
      msr_reg <= '{STD_MSR_CYC, OD_MSR_CYC};
      slot_reg <= '{STD_SLOT_CYC, OD_SLOT_CYC};
      rstl_reg <= '{STD_RSTL_CYC, OD_RSTL_CYC};
    end else if (cfgWrite) begin
      unique case (cfgSelect)
        PAR_W1L: w1l_reg[cfgOverdrive] <= cfgValue;
        PAR_W0L: w0l_reg[cfgOverdrive] <= cfgValue;
        PAR_REC: rec_reg[cfgOverdrive] <= cfgValue;
        PAR_MSR: msr_reg[cfgOverdrive] <= cfgValue;
        PAR_SLOT: slot_reg[cfgOverdrive] <= cfgValue;
        PAR_RSTL: rstl_reg[cfgOverdrive] <= cfgValue;
        default: ;
      endcase
    end
  end

  // Phase boundaries of the running waveform, all from the falling edge
  always_comb begin
    lowTime = w1l_reg[speed_reg];
    riseTime = w0l_reg[speed_reg] + rec_reg[speed_reg];
    endTime = riseTime;
    unique case (kind_reg)
      KIND_RESET: begin
        lowTime = rstl_reg[speed_reg];
        riseTime = rstl_reg[speed_reg] + rstl_reg[speed_reg];
        endTime = riseTime;
      end
      KIND_WRITE0: begin
        lowTime = w0l_reg[speed_reg];
      end
      KIND_WRITE1: ;
      KIND_READ: begin
        if (slot_reg[speed_reg] > endTime) begin
          endTime = slot_reg[speed_reg];
        end
      end
    endcase
  end

  assign startSlot = (state_reg == ST_IDLE) && cmdValid;
  assign lowEnd = (state_reg == ST_LOW) && (tmr.elapsed + 1'b1 >= lowTime);
  assign slotEnd = (state_reg == ST_HIGH) && (tmr.elapsed + 1'b1 >= endTime);
  assign riseEnd = (kind_reg == KIND_READ) && !bit_reg ? slotEnd
    : (state_reg == ST_HIGH) && (tmr.elapsed + 1'b1 >= riseTime);
  assign sampleNow = (state_reg == ST_HIGH) &&
    (tmr.elapsed == msr_reg[speed_reg]);
  assign tmr.restart = startSlot;
  assign cmdReady = (state_reg == ST_IDLE);

  // Waveform sequencer; a master reset aborts it at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      kind_reg <= KIND_RESET;
      last_reg <= 1'b0;
      speed_reg <= 1'b0;
    end else if (masterReset) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmdValid) begin
            state_reg <= ST_LOW;
            kind_reg <= cmdKind;
            last_reg <= cmdLast;
            speed_reg <= overdrive;
          end
        end
        ST_LOW: begin
          if (lowEnd) begin
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (slotEnd) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Line drive: low only in the low phase; weak pullup otherwise
  assign lineOut = 1'b0;
  assign lineOe = (state_reg == ST_LOW);
  assign weakPullupOn = !lineOe;

  // Reply sampling at the msr point for every kind; each kind samples only if that point lies past its own low phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= slotEnd && !masterReset;
      if (startSlot) begin
        bit_reg <= 1'b1;
      end else if (sampleNow) begin
        bit_reg <= lineNow;
      end
    end
  end
  assign doneValid = done_reg;
  assign readBit = bit_reg;

  // Fast-rise trigger: armed after the low phase, fires on the threshold
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
      fastRise_reg <= 1'b0;
    end else if (masterReset || riseEnd || state_reg != ST_HIGH) begin
      armed_reg <= lowEnd && !masterReset;
      fastRise_reg <= 1'b0;
    end else if (armed_reg && aboveNow) begin
      armed_reg <= 1'b0;
      fastRise_reg <= fastRisePullupEnable;
    end
  end

  // Strong pullup enable: host arms it, hardware clears it when it ends
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spuArm_reg <= 1'b0;
    end else if (strongPullupArm) begin
      spuArm_reg <= 1'b1;
    end else if (masterReset || strongPullupDisable) begin
      spuArm_reg <= 1'b0;
    end else if (spu_reg && startSlot) begin
      spuArm_reg <= 1'b0;
    end
  end

  // Strong pullup: starts at the rising edge of the last slot
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spu_reg <= 1'b0;
    end else if (masterReset || strongPullupDisable || !spuArm_reg) begin
      spu_reg <= 1'b0;
    end else if (startSlot) begin
      spu_reg <= 1'b0;
    end else if (armed_reg && aboveNow && last_reg) begin
      spu_reg <= 1'b1;
    end
  end

  // Shared pullup transistor; the host's enable setting is never touched
  assign fastRisePullup = fastRise_reg || spu_reg;
  assign strongPullupOn = spu_reg;
  assign strongPullupArmed = spuArm_reg;

endmodule

// ---- single_wire_pkg.sv ----
// Package for the single-wire slot and pullup controller.
// Assumes a single 50 MHz system clock; all times become cycle counts here.
package single_wire_pkg;

  // Clock rate and width of every timing value
  localparam int CLK_MHZ = 50;
  localparam int TIME_W = 16;

  // Default slot times in ns, standard speed then overdrive speed
  localparam int STD_W1L_NS = 6000;
  localparam int STD_W0L_NS = 60000;
  localparam int STD_REC_NS = 5000;
  localparam int STD_MSR_NS = 13000;
  localparam int STD_SLOT_NS = 70000;
  localparam int STD_RSTL_NS = 480000;
  localparam int OD_W1L_NS = 1000;
  localparam int OD_W0L_NS = 8000;
  localparam int OD_REC_NS = 2000;
  localparam int OD_MSR_NS = 2000;
  localparam int OD_SLOT_NS = 10000;
  localparam int OD_RSTL_NS = 48000;

  // Least times round up to whole cycles
  function automatic logic [TIME_W-1:0] ns2cyc(input int ns);
    int cyc;
    cyc = (ns * CLK_MHZ + 999) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[TIME_W-1:0];
  endfunction

  // Timing set reset values in cycles
  localparam logic [TIME_W-1:0] STD_W1L_CYC = ns2cyc(STD_W1L_NS);
  localparam logic [TIME_W-1:0] STD_W0L_CYC = ns2cyc(STD_W0L_NS);
  localparam logic [TIME_W-1:0] STD_REC_CYC = ns2cyc(STD_REC_NS);
  localparam logic [TIME_W-1:0] STD_MSR_CYC = ns2cyc(STD_MSR_NS);
  localparam logic [TIME_W-1:0] STD_SLOT_CYC = ns2cyc(STD_SLOT_NS);
  localparam logic [TIME_W-1:0] STD_RSTL_CYC = ns2cyc(STD_RSTL_NS);
  localparam logic [TIME_W-1:0] OD_W1L_CYC = ns2cyc(OD_W1L_NS);
  localparam logic [TIME_W-1:0] OD_W0L_CYC = ns2cyc(OD_W0L_NS);
  localparam logic [TIME_W-1:0] OD_REC_CYC = ns2cyc(OD_REC_NS);
  localparam logic [TIME_W-1:0] OD_MSR_CYC = ns2cyc(OD_MSR_NS);
  localparam logic [TIME_W-1:0] OD_SLOT_CYC = ns2cyc(OD_SLOT_NS);
  localparam logic [TIME_W-1:0] OD_RSTL_CYC = ns2cyc(OD_RSTL_NS);

  // Waveform kinds a command may ask for
  typedef enum logic [1:0] {
    KIND_RESET = 2'b00,
    KIND_WRITE0 = 2'b01,
    KIND_WRITE1 = 2'b10,
    KIND_READ = 2'b11
  } slot_kind_t;

  // Timing parameter selectors for configuration writes
  typedef enum logic [2:0] {
    PAR_W1L = 3'b000,
    PAR_W0L = 3'b001,
    PAR_REC = 3'b010,
    PAR_MSR = 3'b011,
    PAR_SLOT = 3'b100,
    PAR_RSTL = 3'b101
  } timing_par_t;

  // Waveform engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10
  } slot_state_t;

endpackage

// ---- slot_timer_if.sv ----
// Interface between the waveform engine and its elapsed-time counter.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/1ps
interface slot_timer_if;
  import single_wire_pkg::*;
  logic restart;
  logic [TIME_W-1:0] elapsed;
  modport engine (output restart, input elapsed);
  modport timer (input restart, output elapsed);
endinterface

// ---- slot_timer.sv ----
// Elapsed-cycle counter measured from the falling edge of a slot.
// Assumes restart is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module slot_timer
  import single_wire_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Engine side
  slot_timer_if.timer tmr
);

  logic [TIME_W-1:0] count_reg;

  // Count up from zero after each restart, holding at the top
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (tmr.restart) begin
      count_reg <= '0;
    end else if (count_reg != {TIME_W{1'b1}}) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign tmr.elapsed = count_reg;

endmodule

// ---- single_wire_slot_pullup_ctrl_assertions.sv ----
// Port checker for the slot and pullup controller.
// Assumes a bind into the top module, all on sys_clk.
`timescale 1ns/1ps
module single_wire_slot_pullup_ctrl_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic doneValid,
  input wire logic fastRisePullupEnable,
  input wire logic strongPullupDisable,
  input wire logic masterReset,
  input wire logic pullupOnThreshold,
  input wire logic strongPullupArmed,
  input wire logic strongPullupOn,
  input wire logic lineOe,
  input wire logic weakPullupOn,
  input wire logic fastRisePullup
);
  // One clock domain for every check
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Line drive and slot framing
  chk_oe_from_cmd: assert property ($rose(lineOe) |->
    $past(cmdValid) || $past(cmdValid, 2)) else $error("fall unasked");
  chk_oe_busy: assert property (lineOe |-> !cmdReady)
    else $error("drive while idle");
  chk_done_idle: assert property (doneValid |->
    cmdReady && !lineOe ##1 !doneValid) else $error("done bad");
  chk_release_weak: assert property ($fell(lineOe) |->
    weakPullupOn && !fastRisePullup) else $error("release bad");
  // Fast-rise pullup
  chk_fast_thresh: assert property ($rose(fastRisePullup) |->
    $past(pullupOnThreshold)) else $error("pullup early");
  chk_fast_in_slot: assert property (fastRisePullup
    && !strongPullupOn |-> fastRisePullupEnable &&
    (!cmdReady || !$past(cmdReady))) else $error("pullup outside slot");
  // Strong pullup
  chk_spu_start: assert property ($rose(strongPullupOn) |->
    $past(strongPullupArmed) && !lineOe) else $error("strong unarmed");
  chk_spu_holds: assert property (strongPullupOn && !masterReset &&
    !strongPullupDisable && !cmdValid && !$past(cmdValid) |=>
    strongPullupOn) else $error("strong dropped");
  chk_spu_ends: assert property (masterReset || strongPullupDisable
    |=> !strongPullupOn && !strongPullupArmed) else $error("strong kept");
  chk_spu_clears: assert property ($fell(strongPullupOn) |->
    !strongPullupArmed) else $error("enable kept");
  chk_spu_shares: assert property (strongPullupOn |-> fastRisePullup)
    else $error("transistor off");
endmodule
bind single_wire_slot_pullup_ctrl single_wire_slot_pullup_ctrl_assertions
  chk_u (.sys_clk, .rst_b, .cmdValid, .cmdReady, .doneValid,
  .fastRisePullupEnable, .strongPullupDisable, .masterReset,
  .pullupOnThreshold, .strongPullupArmed, .strongPullupOn, .lineOe,
  .weakPullupOn, .fastRisePullup);

// ---- slave_model.sv ----
// Slave model answering read slots on the shared line.
// Assumes the answer bit is set before the slot's falling edge.
`timescale 1ns/1ps
module slave_model #(
  parameter int HOLD = 12
) (
  // Clock
  input wire logic sys_clk,
  // Line and answer
  input wire logic line,
  input wire logic answerBit,
  output logic pullDown
);
  logic lineReg = 1'h1;
  int cnt = 0;
  // Pull low after the master's fall to answer zero
  always @(posedge sys_clk) begin
    lineReg <= line;
    if (lineReg && !line && !answerBit) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // A one leaves the line alone
  assign pullDown = cnt > 0;
endmodule

// ---- test_single_wire_slot_pullup_ctrl.sv ----
// Bench for the slot and pullup controller against a slave model.
// Assumes an open-drain line with a pull-up; threshold follows it.
`timescale 1ns/1ps
module test_single_wire_slot_pullup_ctrl;
  import single_wire_pkg::*;
  typedef struct {logic bitExp; slot_kind_t kind; int low; int span;
    int pull;} note_t;
  logic sys_clk = 1'h0, rst_b = 1'h0, cmdValid = 1'h0, cmdLast = 1'h0;
  logic overdrive = 1'h0, fastRisePullupEnable = 1'h1, answerBit = 1'h1;
  logic strongPullupArm = 1'h0, strongPullupDisable = 1'h0;
  logic masterReset = 1'h0, cfgWrite = 1'h0, cfgOverdrive = 1'h0;
  slot_kind_t cmdKind = KIND_RESET;
  timing_par_t cfgSelect = PAR_W1L;
  logic [TIME_W-1:0] cfgValue = '0;
  logic cmdReady, doneValid, readBit, strongPullupArmed, strongPullupOn;
  logic lineOut, lineOe, weakPullupOn, fastRisePullup, pullDown;
  wire logic lineIn = !((lineOe && !lineOut) || pullDown);
  wire logic pullupOnThreshold = lineIn;
  int mismatches = 0, tests_run = 0, runLow = 0, runSpan = 0;
  int lastLow = 0, lastSpan = 0, lastPull = 0;
  // Cycles the slave holds a zero answer after it sees the fall
  localparam int HOLD_CYC = 12;
  int tm [2][6] = '{'{3, 14, 4, 9, 24, 20}, '{2, 10, 3, 7, 16, 16}};
  logic [31:0] rng = 32'h12;
  note_t notes [$];
  note_t n;
  // Free-running clock
  always #10 sys_clk = ~sys_clk;
  // Device and the slave on its line
  single_wire_slot_pullup_ctrl dut_u (.sys_clk, .rst_b, .cmdValid, .cmdKind,
    .cmdLast, .cmdReady, .doneValid, .readBit, .overdrive,
    .fastRisePullupEnable, .strongPullupArm, .strongPullupDisable,
    .masterReset, .cfgWrite, .cfgOverdrive, .cfgSelect, .cfgValue,
    .strongPullupArmed, .strongPullupOn, .lineIn, .pullupOnThreshold,
    .lineOut, .lineOe, .weakPullupOn, .fastRisePullup);
  slave_model #(.HOLD(HOLD_CYC)) slave_u (.sys_clk, .line(lineIn),
    .answerBit, .pullDown);
  // Helpers: random source, compares, waits, verdict
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic compare_bit(input logic e, input logic g, input string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic compare_count(input int e, input int g, input string m);
    tests_run++;
    if (g != e) begin
      mismatches++;
      $display("wrong value at %0t: %s %0d not %0d", $time, m, g, e);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_cond(input logic drained);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge sys_clk);
      if (drained ? notes.size() == 0 : cmdReady === 1'h1) begin
        return;
      end
    end
    mismatches++;
    finish_test;
  endtask
  // Request one waveform, note its expected result, wait until taken
  task automatic run_slot(input slot_kind_t k, input logic od, a, last);
    int t [6];
    int stop, rise;
    note_t x;
    t = tm[od];
    x.kind = k;
    // Only read slots expect the answer; other kinds expect a one
    x.bitExp = (k == KIND_READ) ? a : 1'h1;
    x.low = (k == KIND_RESET) ? t[5] : (k == KIND_WRITE0) ? t[1] : t[0];
    x.span = (k == KIND_RESET) ? 2 * t[5] : t[1] + t[2];
    if (k == KIND_READ && t[4] > x.span) begin
      x.span = t[4];
    end
    // Fast-rise pullup: fires two sync stages and one register after
    // the line rises, unless its end comes first; last seen at its end
    stop = (k == KIND_RESET || (k == KIND_READ && !a)) ? x.span
      : t[1] + t[2];
    rise = (k == KIND_READ && !a) ? HOLD_CYC + 1 : x.low;
    x.pull = (fastRisePullupEnable && rise + 3 < stop) ? stop : 0;
    notes.push_back(x);
    cmdValid <= 1'h1;
    cmdKind <= k;
    overdrive <= od;
    cmdLast <= last;
    wait_cond(1'h0);
    answerBit <= a | (k != KIND_READ);
  endtask
  // Measure each slot and check it against the oldest note
  always @(posedge sys_clk) begin
    if (lineOe === 1'h1) begin
      runLow++;
    end else if (runLow > 0) begin
      lastLow = runLow;
      runLow = 0;
    end
    if (cmdReady === 1'h0) begin
      runSpan++;
    end else if (runSpan > 0) begin
      lastSpan = runSpan;
      runSpan = 0;
    end
    if (fastRisePullup === 1'h1 && strongPullupOn !== 1'h1) begin
      lastPull = runSpan;
    end
    if (doneValid === 1'h1 && notes.size() > 0) begin
      n = notes.pop_front();
      compare_count(n.low, lastLow, "low");
      compare_bit(1'h1, lastSpan >= n.span, "short slot");
      compare_count(n.pull, lastPull, "pull");
      lastPull = 0;
      if (n.kind == KIND_READ || n.kind == KIND_RESET) begin
        compare_bit(n.bitExp, readBit, "sampled bit");
      end
    end
  end
  // Reset, timing set-up, random slots, then strong pullup endings
  initial begin
    int i, j;
    repeat (4) @(posedge sys_clk);
    compare_bit(1'h1, cmdReady & !lineOe & !fastRisePullup,
      "reset");
    rst_b <= 1'h1;
    for (i = 0; i < 12; i++) begin
      cfgWrite <= 1'h1;
      cfgOverdrive <= (i >= 6);
      cfgSelect <= timing_par_t'(i % 6);
      cfgValue <= TIME_W'(tm[i / 6][i % 6]);
      @(posedge sys_clk);
    end
    cfgWrite <= 1'h0;
    for (j = 1; j >= 0; j--) begin
      fastRisePullupEnable <= j[0];
      @(posedge sys_clk);
      for (i = 0; i < 16; i++) begin
        rng = xs(rng);
        run_slot(slot_kind_t'(rng[1:0]), rng[2], rng[3], 1'h0);
      end
      cmdValid <= 1'h0;
      wait_cond(1'h1);
    end
    for (i = 0; i < 3; i++) begin
      strongPullupArm <= 1'h1;
      @(posedge sys_clk);
      strongPullupArm <= 1'h0;
      run_slot(KIND_WRITE1, i[0], 1'h1, 1'h1);
      cmdValid <= 1'h0;
      wait_cond(1'h1);
      repeat (3) @(posedge sys_clk);
      compare_bit(1'h1, strongPullupOn, "strong off");
      strongPullupDisable <= (i == 1);
      masterReset <= (i == 2);
      if (i == 0) begin
        run_slot(KIND_READ, 1'h0, 1'h1, 1'h0);
        cmdValid <= 1'h0;
      end
      @(posedge sys_clk);
      strongPullupDisable <= 1'h0;
      masterReset <= 1'h0;
      repeat (3) @(posedge sys_clk);
      compare_bit(1'h0, strongPullupOn | strongPullupArmed,
        "kept");
      wait_cond(1'h1);
    end
    finish_test;
  end
endmodule
